//--- src/exec_pkg.sv
// register map, opcodes and constants of the execution block
package exec_pkg;
  localparam logic [5:0] OFS_CMD = 6'h00;
  localparam logic [5:0] OFS_OPD = 6'h04;
  localparam logic [5:0] OFS_PC = 6'h08;
  localparam logic [5:0] OFS_ZPTR = 6'h0c;
  localparam logic [5:0] OFS_STACK = 6'h10;
  localparam logic [5:0] OFS_OFFSET = 6'h14;
  localparam logic [5:0] OFS_FLAGS = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;
  localparam logic [5:0] OFS_PROD = 6'h20;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_TWO_BIT = 8;
  localparam int CMD_SEL_LSB = 16;
  localparam int OPD_A_LSB = 0;
  localparam int OPD_B_LSB = 8;
  localparam int OPD_IO_LSB = 16;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RESWR_BIT = 1;
  localparam int ST_PAIRWR_BIT = 2;
  localparam int ST_CYC_LSB = 8;
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MIN = 8'h80;
  localparam logic [7:0] BYTE_MAX = 8'h7f;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  typedef enum logic [5:0] {
    OP_DISJ, OP_DISJ_IMM, OP_XDISJ, OP_INV1, OP_MINUS2, OP_SETMASK,
    OP_CLRMASK, OP_ADD1, OP_SUB1, OP_ZSTEST, OP_ZEROREG, OP_ONESREG,
    OP_UPROD, OP_SPROD, OP_MPROD, OP_FUPROD, OP_FSPROD, OP_FMPROD,
    OP_RJUMP, OP_PJUMP, OP_RSUB, OP_PSUB, OP_SUBEXIT, OP_IRQEXIT,
    OP_EQSKIP, OP_CMP, OP_CMPC, OP_CMPI, OP_SKRLO, OP_SKRHI,
    OP_SKIOLO, OP_SKIOHI, OP_BRFHI, OP_BRFLO, OP_BREQUAL, OP_BRUNEQ
  } opcode_t;
endpackage : exec_pkg

//--- src/cpu_logic_mul_branch_exec.sv
// execution unit for logic, multiply, jump, skip and branch operations
// Behaviour
// - or forms write dest or operand, ZNV
// - xor writes dest xor source, ZNV
// - invert is ff minus; negate is zero minus
// - clear mask ands with ff minus constant
// - all ones loads ff, flags kept
// - inc dec test clear: one cycle, ZNV
// - products land in pair, two cycles
// - fraction products shifted left one, two cycles
// - relative and pointer jumps, two cycles
// - calls three cycles, exits four, interrupt exit sets I
// - compares only set flags, one cycle
// - equal skip advances two or three
// - register bit skips on clear or set
// - io bit skips on clear or set
// - flag branch to pc plus k plus one
// - equal branch when zero flag set
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cpu_logic_mul_branch_exec #(
  parameter int PC_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import exec_pkg::*;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    opcode_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] io;
    logic [2:0] sel;
    logic two;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] z;
    logic [PC_W-1:0] stk;
    logic [PC_W-1:0] k;
    logic [7:0] flags;
    logic [15:0] prod;
    logic resWr;
    logic pairWr;
    logic busy;
    logic [2:0] cnt;
    logic [2:0] lastCyc;
  } state_t;

  localparam state_t ST_RST = '{waitReq: 1'b1, op: OP_DISJ, pc: PC_W'(PC_RST),
    flags: FLAGS_RST, default: '0};

  state_t q;
  state_t n;
  logic commit;
  logic cond;
  logic logicFl;
  logic useSub;
  logic resWr;
  logic pairWr;
  logic cin;
  logic v;
  logic [2:0] cyc;
  logic [7:0] res;
  logic [7:0] fl;
  logic [7:0] sx;
  logic [7:0] sy;
  logic [8:0] diff;
  logic [15:0] prod;
  logic signed [8:0] ma;
  logic signed [8:0] mb;
  logic signed [17:0] full;
  logic [PC_W-1:0] pcN;
  logic [PC_W-1:0] stkN;
  logic [PC_W-1:0] rel;
  logic [PC_W-1:0] seq;
  logic [31:0] rd;

  always_comb
  begin
    n = q;
    commit = 1'b0;
    cond = 1'b0;
    logicFl = 1'b0;
    useSub = 1'b0;
    resWr = 1'b0;
    pairWr = 1'b0;
    v = 1'b0;
    cyc = CYC_1;
    res = q.a;
    fl = q.flags;
    prod = q.prod;
    stkN = q.stk;
    rel = q.pc + q.k + PC_W'(1);
    seq = q.pc + PC_W'(1);
    pcN = seq;
    rd = '0;
    // one multiplier serves all six products by sign extension choice
    ma = (q.op inside {OP_SPROD, OP_MPROD, OP_FSPROD, OP_FMPROD}) ? {q.a[7], q.a} : {1'b0, q.a};
    mb = (q.op inside {OP_SPROD, OP_FSPROD}) ? {q.b[7], q.b} : {1'b0, q.b};
    full = ma * mb;
    // one subtractor serves negate and the three compares
    sx = (q.op == OP_MINUS2) ? BYTE_ZERO : q.a;
    sy = (q.op == OP_MINUS2) ? q.a : q.b;
    cin = (q.op == OP_CMPC) ? q.flags[FL_C] : 1'b0;
    diff = {1'b0, sx} - {1'b0, sy} - {8'h00, cin};
    case (q.op)
      OP_DISJ, OP_DISJ_IMM, OP_SETMASK:
      begin
        res = q.a | q.b;
        resWr = 1'b1;
        logicFl = 1'b1;
      end
      OP_XDISJ:
      begin
        res = q.a ^ q.b;
        resWr = 1'b1;
        logicFl = 1'b1;
      end
      OP_INV1:
      begin
        res = BYTE_ONES - q.a;
        resWr = 1'b1;
        logicFl = 1'b1;
        fl[FL_C] = 1'b1;
      end
      OP_MINUS2:
      begin
        res = diff[7:0];
        resWr = 1'b1;
        useSub = 1'b1;
      end
      OP_CLRMASK:
      begin
        res = q.a & (BYTE_ONES - q.b);
        resWr = 1'b1;
        logicFl = 1'b1;
      end
      OP_ADD1:
      begin
        res = q.a + 8'h01;
        resWr = 1'b1;
        logicFl = 1'b1;
        v = (res == BYTE_MIN);
      end
      OP_SUB1:
      begin
        res = q.a - 8'h01;
        resWr = 1'b1;
        logicFl = 1'b1;
        v = (res == BYTE_MAX);
      end
      OP_ZSTEST:
      begin
        res = q.a & q.a;
        resWr = 1'b1;
        logicFl = 1'b1;
      end
      OP_ZEROREG:
      begin
        res = q.a ^ q.a;
        resWr = 1'b1;
        logicFl = 1'b1;
      end
      OP_ONESREG:
      begin
        res = BYTE_ONES;
        resWr = 1'b1;
      end
      OP_UPROD, OP_SPROD, OP_MPROD:
      begin
        prod = full[15:0];
        pairWr = 1'b1;
        cyc = CYC_2;
        fl[FL_C] = full[15];
        fl[FL_Z] = (prod == 16'h0000);
      end
      OP_FUPROD, OP_FSPROD, OP_FMPROD:
      begin
        prod = {full[14:0], 1'b0};
        pairWr = 1'b1;
        cyc = CYC_2;
        fl[FL_C] = full[15];
        fl[FL_Z] = (prod == 16'h0000);
      end
      OP_RJUMP, OP_PJUMP:
      begin
        pcN = (q.op == OP_RJUMP) ? rel : q.z;
        cyc = CYC_2;
      end
      OP_RSUB, OP_PSUB:
      begin
        pcN = (q.op == OP_RSUB) ? rel : q.z;
        stkN = seq;
        cyc = CYC_3;
      end
      OP_SUBEXIT, OP_IRQEXIT:
      begin
        pcN = q.stk;
        cyc = CYC_4;
        fl[FL_I] = (q.op == OP_IRQEXIT) | q.flags[FL_I];
      end
      OP_CMP, OP_CMPC, OP_CMPI:
      begin
        useSub = 1'b1;
      end
      OP_EQSKIP:
        cond = (q.a == q.b);
      OP_SKRLO:
        cond = !q.a[q.sel];
      OP_SKRHI:
        cond = q.a[q.sel];
      OP_SKIOLO:
        cond = !q.io[q.sel];
      OP_SKIOHI:
        cond = q.io[q.sel];
      OP_BRFHI:
        cond = q.flags[q.sel];
      OP_BRFLO:
        cond = !q.flags[q.sel];
      OP_BREQUAL:
        cond = q.flags[FL_Z];
      OP_BRUNEQ:
        cond = !q.flags[FL_Z];
      default:
        cyc = CYC_1;
    endcase
    // skip over one or two words
    if (q.op inside {OP_EQSKIP, OP_SKRLO, OP_SKRHI, OP_SKIOLO, OP_SKIOHI} && cond)
    begin
      cyc = q.two ? CYC_3 : CYC_2;
      pcN = q.pc + PC_W'(cyc);
    end
    if (q.op inside {OP_BRFHI, OP_BRFLO, OP_BREQUAL, OP_BRUNEQ} && cond)
    begin
      cyc = CYC_2;
      pcN = rel;
    end
    if (logicFl)
    begin
      fl[FL_Z] = (res == BYTE_ZERO);
      fl[FL_N] = res[7];
      fl[FL_V] = v;
    end
    // subtract flags, chained zero for carry form
    if (useSub)
    begin
      fl[FL_Z] = (diff[7:0] == BYTE_ZERO) & ((q.op != OP_CMPC) | q.flags[FL_Z]);
      fl[FL_N] = diff[7];
      fl[FL_C] = diff[8];
      fl[FL_V] = (sx[7] & ~sy[7] & ~diff[7]) | (~sx[7] & sy[7] & diff[7]);
      fl[FL_H] = (~sx[3] & sy[3]) | (sy[3] & diff[3]) | (diff[3] & ~sx[3]);
    end
    // results appear only once the documented cycle count has run out
    if (q.busy)
    begin
      n.cnt = q.cnt + 3'h1;
      if (n.cnt == cyc)
      begin
        commit = 1'b1;
        n.busy = 1'b0;
        n.lastCyc = cyc;
        n.resWr = resWr;
        n.pairWr = pairWr;
        n.a = resWr ? res : q.a;
        n.prod = pairWr ? prod : q.prod;
        n.flags = fl;
        n.pc = pcN;
        n.stk = stkN;
      end
    end
    case (address)
      OFS_OPD: rd = {8'h00, q.io, q.b, q.a};
      OFS_PC: rd = 32'(q.pc);
      OFS_ZPTR: rd = 32'(q.z);
      OFS_STACK: rd = 32'(q.stk);
      OFS_OFFSET: rd = 32'(q.k);
      OFS_FLAGS: rd = {24'h000000, q.flags};
      OFS_PROD: rd = {16'h0000, q.prod};
      OFS_STATUS:
      begin
        rd[ST_BUSY_BIT] = q.busy;
        rd[ST_RESWR_BIT] = q.resWr;
        rd[ST_PAIRWR_BIT] = q.pairWr;
        rd[ST_CYC_LSB +: 3] = q.lastCyc;
      end
      default: rd = '0;
    endcase
    // writes stall while busy so operands cannot change mid-operation
    n.waitReq = !(q.waitReq && (read || write) && !(write && q.busy));
    if (q.waitReq && read)
    begin
      n.rdata = rd;
    end
    if (!q.waitReq && write)
    begin
      case (address)
        OFS_CMD:
        begin
          n.op = opcode_t'(writedata[CMD_OP_LSB +: 6]);
          n.two = writedata[CMD_TWO_BIT];
          n.sel = writedata[CMD_SEL_LSB +: 3];
          n.busy = 1'b1;
          n.cnt = 3'h0;
          n.resWr = 1'b0;
          n.pairWr = 1'b0;
        end
        OFS_OPD:
        begin
          n.a = writedata[OPD_A_LSB +: 8];
          n.b = writedata[OPD_B_LSB +: 8];
          n.io = writedata[OPD_IO_LSB +: 8];
        end
        OFS_PC: n.pc = writedata[PC_W-1:0];
        OFS_ZPTR: n.z = writedata[PC_W-1:0];
        OFS_STACK: n.stk = writedata[PC_W-1:0];
        OFS_OFFSET: n.k = writedata[PC_W-1:0];
        OFS_FLAGS: n.flags = writedata[7:0];
        default: n.a = q.a;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= ST_RST;
    end
    else
    begin
      q <= n;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = q.waitReq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_disj;
    commit && q.op inside {OP_DISJ, OP_DISJ_IMM, OP_SETMASK} |=> q.a == ($past(q.a) | q.b)
      && q.flags[FL_C] == $past(q.flags[FL_C]) && q.lastCyc == CYC_1;
  endproperty
  a_disj: assert property (p_disj) else $error("or result wrong");
  property p_xdisj;
    commit && q.op == OP_XDISJ |=> q.a == ($past(q.a) ^ q.b) && !q.flags[FL_V];
  endproperty
  a_xdisj: assert property (p_xdisj) else $error("xor result wrong");
  property p_inv;
    commit && q.op == OP_INV1 |=> q.a == BYTE_ONES - $past(q.a) && q.flags[FL_C];
  endproperty
  a_inv: assert property (p_inv) else $error("invert wrong");
  property p_clrmask;
    commit && q.op == OP_CLRMASK |=> q.a == ($past(q.a) & (BYTE_ONES - q.b));
  endproperty
  a_clrmask: assert property (p_clrmask) else $error("clear mask wrong");
  property p_ones;
    commit && q.op == OP_ONESREG |=> q.a == BYTE_ONES && q.flags == $past(q.flags);
  endproperty
  a_ones: assert property (p_ones) else $error("all ones wrong");
  property p_add1;
    commit && q.op == OP_ADD1 |=> q.a == $past(q.a) + 8'h01
      && q.flags[FL_C] == $past(q.flags[FL_C]) && q.lastCyc == CYC_1;
  endproperty
  a_add1: assert property (p_add1) else $error("increment wrong");
  property p_prod_time;
    $rose(q.busy) && q.op inside {OP_UPROD, OP_SPROD, OP_MPROD} |-> ##1 (q.busy && commit)
      ##1 (!q.busy && q.pairWr);
  endproperty
  a_prod_time: assert property (p_prod_time) else $error("product timing wrong");
  property p_frac;
    commit && q.op == OP_FUPROD |=> q.prod == 16'(({8'h00, $past(q.a)} * {8'h00, q.b}) << 1)
      && q.lastCyc == CYC_2;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction product wrong");
  property p_rjump;
    commit && q.op == OP_RJUMP |=> q.pc == $past(q.pc) + q.k + PC_W'(1)
      && q.lastCyc == CYC_2 && q.flags == $past(q.flags);
  endproperty
  a_rjump: assert property (p_rjump) else $error("relative jump wrong");
  property p_irqexit;
    commit && q.op == OP_IRQEXIT |=> q.pc == q.stk && q.flags[FL_I] && q.lastCyc == CYC_4;
  endproperty
  a_irqexit: assert property (p_irqexit) else $error("interrupt exit wrong");
  property p_cmp;
    commit && q.op inside {OP_CMP, OP_CMPC, OP_CMPI} |=> q.a == $past(q.a) && !q.resWr
      && q.lastCyc == CYC_1;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote result");
  property p_eqskip;
    commit && q.op == OP_EQSKIP && q.a == q.b && q.two |=> q.pc == $past(q.pc) + PC_W'(3)
      && q.lastCyc == CYC_3;
  endproperty
  a_eqskip: assert property (p_eqskip) else $error("equal skip wrong");
  property p_skr;
    commit && q.op == OP_SKRLO && !q.a[q.sel] && !q.two |=> q.pc == $past(q.pc) + PC_W'(2)
      && q.lastCyc == CYC_2;
  endproperty
  a_skr: assert property (p_skr) else $error("register bit skip wrong");
  property p_skio;
    commit && q.op == OP_SKIOHI && !q.io[q.sel] |=> q.pc == $past(q.pc) + PC_W'(1)
      && q.lastCyc == CYC_1;
  endproperty
  a_skio: assert property (p_skio) else $error("io bit skip wrong");
  property p_brf;
    commit && q.op == OP_BRFHI && q.flags[q.sel] |=> q.pc == $past(q.pc) + q.k + PC_W'(1)
      && q.lastCyc == CYC_2;
  endproperty
  a_brf: assert property (p_brf) else $error("flag branch wrong");
  property p_branch_equal;
    commit && q.op == OP_BREQUAL && !q.flags[FL_Z] |=> q.pc == $past(q.pc) + PC_W'(1)
      && q.lastCyc == CYC_1;
  endproperty
  a_branch_equal: assert property (p_branch_equal) else $error("equal branch wrong");
  property p_skiplen;
    commit && cond && q.op inside {OP_EQSKIP, OP_SKRLO, OP_SKRHI, OP_SKIOLO, OP_SKIOHI}
      |=> q.lastCyc == (q.two ? CYC_3 : CYC_2) && q.pc - $past(q.pc) == PC_W'(q.lastCyc);
  endproperty
  a_skiplen: assert property (p_skiplen) else $error("skip length wrong");

  c_prod: cover property (commit && q.op == OP_SPROD);
  c_call: cover property (commit && q.op == OP_RSUB);
  c_skip3: cover property (commit && cond && q.two && q.op == OP_SKIOHI);
  c_stall: cover property (write && q.busy && q.waitReq);
endmodule : cpu_logic_mul_branch_exec

//--- sim/tb.sv
// self-checking bench of the execution block
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;
  logic clk;
  logic rst_n;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rd;
  logic [15:0] kOff;
  int num_errors;
  int comparisons;

  cpu_logic_mul_branch_exec #(.PC_W(16)) uut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low; stalls bounded by the bench
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    chk("bus answer", 32'h0, {31'h0, waitrequest});
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // loads operands, starts one operation, waits for it and checks cycles, dest, flags and pc
  task automatic step(input opcode_t op, input logic [3:0] ctl, input logic [23:0] opd,
    input logic [7:0] fl, input logic [7:0] eRes, input logic [7:0] eFl,
    input logic [15:0] ePc, input logic [2:0] eCyc);
    int n;
    n = 0;
    bus(1'b1, OFS_OPD, {8'h00, opd});
    bus(1'b1, OFS_PC, 32'h0000_0100);
    bus(1'b1, OFS_FLAGS, {24'h0, fl});
    bus(1'b1, OFS_OFFSET, {16'h0, kOff});
    bus(1'b1, OFS_CMD, {13'h0, ctl[2:0], 7'h0, ctl[3], 2'h0, op});
    do
    begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 20);
    chk("cycles", {29'h0, eCyc}, {29'h0, rd[10:8]});
    bus(1'b0, OFS_OPD, 32'h0);
    chk("dest", {24'h0, eRes}, {24'h0, rd[7:0]});
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", {24'h0, eFl}, rd);
    bus(1'b0, OFS_PC, 32'h0);
    chk("pc", {16'h0, ePc}, rd);
    bus(1'b0, OFS_PROD, 32'h0);
  endtask : step

  task automatic t_reset;
    bus(1'b0, OFS_PC, 32'h0);
    chk("pc reset", 32'h0, rd);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags reset", 32'h0, rd);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h0, rd);
    // unmapped place is answered, ignores writes and reads zero
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    bus(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_logic;
    step(OP_DISJ, 4'h0, 24'h000a50, 8'hff, 8'h5a, 8'hf1, 16'h0101, 3'h1);
    step(OP_DISJ_IMM, 4'h0, 24'h000180, 8'h00, 8'h81, 8'h04, 16'h0101, 3'h1);
    step(OP_SETMASK, 4'h0, 24'h000000, 8'h00, 8'h00, 8'h02, 16'h0101, 3'h1);
    step(OP_XDISJ, 4'h0, 24'h00c33c, 8'hff, 8'hff, 8'hf5, 16'h0101, 3'h1);
    step(OP_INV1, 4'h0, 24'h00000f, 8'h00, 8'hf0, 8'h05, 16'h0101, 3'h1);
    step(OP_MINUS2, 4'h0, 24'h000001, 8'h00, 8'hff, 8'h25, 16'h0101, 3'h1);
    step(OP_MINUS2, 4'h0, 24'h000080, 8'h00, 8'h80, 8'h0d, 16'h0101, 3'h1);
    step(OP_CLRMASK, 4'h0, 24'h000fff, 8'h00, 8'hf0, 8'h04, 16'h0101, 3'h1);
    step(OP_ONESREG, 4'h0, 24'h000012, 8'h5a, 8'hff, 8'h5a, 16'h0101, 3'h1);
    step(OP_ADD1, 4'h0, 24'h00007f, 8'h01, 8'h80, 8'h0d, 16'h0101, 3'h1);
    step(OP_SUB1, 4'h0, 24'h000080, 8'h01, 8'h7f, 8'h09, 16'h0101, 3'h1);
    step(OP_ZSTEST, 4'h0, 24'h000000, 8'h0d, 8'h00, 8'h03, 16'h0101, 3'h1);
    step(OP_ZEROREG, 4'h0, 24'h000055, 8'h0d, 8'h00, 8'h03, 16'h0101, 3'h1);
    step(OP_CMP, 4'h0, 24'h002010, 8'h00, 8'h10, 8'h05, 16'h0101, 3'h1);
    step(OP_CMPC, 4'h0, 24'h002021, 8'h01, 8'h21, 8'h00, 16'h0101, 3'h1);
    step(OP_CMPC, 4'h0, 24'h002020, 8'h01, 8'h20, 8'h25, 16'h0101, 3'h1);
    step(OP_CMPI, 4'h0, 24'h000180, 8'h00, 8'h80, 8'h28, 16'h0101, 3'h1);
    $display("test logic done");
  endtask : t_logic

  task automatic t_prod;
    step(OP_UPROD, 4'h0, 24'h00ffff, 8'hfc, 8'hff, 8'hfd, 16'h0101, 3'h2);
    chk("prod", 32'h0000_fe01, rd);
    step(OP_SPROD, 4'h0, 24'h0001ff, 8'hfc, 8'hff, 8'hfd, 16'h0101, 3'h2);
    chk("prod", 32'h0000_ffff, rd);
    step(OP_MPROD, 4'h0, 24'h000280, 8'hfc, 8'h80, 8'hfd, 16'h0101, 3'h2);
    chk("prod", 32'h0000_ff00, rd);
    step(OP_FUPROD, 4'h0, 24'h008080, 8'hfc, 8'h80, 8'hfc, 16'h0101, 3'h2);
    chk("prod", 32'h0000_8000, rd);
    step(OP_FSPROD, 4'h0, 24'h005500, 8'hfc, 8'h00, 8'hfe, 16'h0101, 3'h2);
    chk("prod", 32'h0000_0000, rd);
    step(OP_FMPROD, 4'h0, 24'h0040c0, 8'hfc, 8'hc0, 8'hfd, 16'h0101, 3'h2);
    chk("prod", 32'h0000_e000, rd);
    $display("test products done");
  endtask : t_prod

  task automatic t_flow;
    bus(1'b1, OFS_ZPTR, 32'h0000_0abc);
    bus(1'b1, OFS_STACK, 32'h0000_0555);
    step(OP_RJUMP, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h0111, 3'h2);
    kOff = 16'hfff0;
    step(OP_RJUMP, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h00f1, 3'h2);
    kOff = 16'h0010;
    step(OP_PJUMP, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h0abc, 3'h2);
    step(OP_SUBEXIT, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h0555, 3'h4);
    step(OP_IRQEXIT, 4'h0, 24'h0, 8'h3f, 8'h00, 8'hbf, 16'h0555, 3'h4);
    step(OP_RSUB, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h0111, 3'h3);
    bus(1'b0, OFS_STACK, 32'h0);
    chk("stack", 32'h0000_0101, rd);
    bus(1'b1, OFS_STACK, 32'h0000_0555);
    step(OP_PSUB, 4'h0, 24'h0, 8'h3f, 8'h00, 8'h3f, 16'h0abc, 3'h3);
    bus(1'b0, OFS_STACK, 32'h0);
    chk("stack", 32'h0000_0101, rd);
    // a write issued mid-operation must wait, so the exit cannot overwrite it
    bus(1'b1, OFS_STACK, 32'h0000_0555);
    bus(1'b1, OFS_CMD, {26'h0, OP_IRQEXIT});
    bus(1'b1, OFS_FLAGS, 32'h0000_0012);
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk("flags after stall", 32'h0000_0012, rd);
    $display("test flow done");
  endtask : t_flow

  task automatic t_skip;
    step(OP_EQSKIP, 4'h0, 24'h003333, 8'h3f, 8'h33, 8'h3f, 16'h0102, 3'h2);
    step(OP_EQSKIP, 4'h8, 24'h003333, 8'h3f, 8'h33, 8'h3f, 16'h0103, 3'h3);
    step(OP_EQSKIP, 4'h8, 24'h003433, 8'h3f, 8'h33, 8'h3f, 16'h0101, 3'h1);
    step(OP_SKRLO, 4'h3, 24'h000808, 8'h3f, 8'h08, 8'h3f, 16'h0101, 3'h1);
    step(OP_SKRLO, 4'hb, 24'h00f7f7, 8'h3f, 8'hf7, 8'h3f, 16'h0103, 3'h3);
    step(OP_SKRHI, 4'h3, 24'h000808, 8'h3f, 8'h08, 8'h3f, 16'h0102, 3'h2);
    step(OP_SKIOLO, 4'h7, 24'h7f0000, 8'h3f, 8'h00, 8'h3f, 16'h0102, 3'h2);
    step(OP_SKIOHI, 4'h0, 24'hfe0000, 8'h3f, 8'h00, 8'h3f, 16'h0101, 3'h1);
    step(OP_SKIOHI, 4'h8, 24'h010000, 8'h3f, 8'h00, 8'h3f, 16'h0103, 3'h3);
    $display("test skip done");
  endtask : t_skip

  task automatic t_branch;
    logic [7:0] m;
    for (int s = 0; s < 8; s++)
    begin
      m = 8'(1 << s);
      step(OP_BRFHI, {1'b0, 3'(s)}, 24'h0, m, 8'h00, m, 16'h0111, 3'h2);
      step(OP_BRFHI, {1'b0, 3'(s)}, 24'h0, ~m, 8'h00, ~m, 16'h0101, 3'h1);
      step(OP_BRFLO, {1'b0, 3'(s)}, 24'h0, ~m, 8'h00, ~m, 16'h0111, 3'h2);
      step(OP_BRFLO, {1'b0, 3'(s)}, 24'h0, m, 8'h00, m, 16'h0101, 3'h1);
    end
    step(OP_BREQUAL, 4'h0, 24'h0, 8'h02, 8'h00, 8'h02, 16'h0111, 3'h2);
    step(OP_BREQUAL, 4'h0, 24'h0, 8'hfd, 8'h00, 8'hfd, 16'h0101, 3'h1);
    step(OP_BRUNEQ, 4'h0, 24'h0, 8'hfd, 8'h00, 8'hfd, 16'h0111, 3'h2);
    $display("test branch done");
  endtask : t_branch

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // the whole run needs some 2400 cycles; a hang is cut off well beyond
  initial
  begin
    #(40 * 60000);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    kOff = 16'h0010;
    num_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_logic();
    t_prod();
    t_flow();
    t_skip();
    t_branch();
    print_verdict();
  end
endmodule : tb
